/* core/wwt_params.svh */
// Constants for the windowed watchdog: offsets, reset values, timing
`ifndef WWT_PARAMS_SVH
`define WWT_PARAMS_SVH

// Register byte addresses
`define WWT_ADDR_LOAD 32'h4000_4000
`define WWT_ADDR_COUNT 32'h4000_4004
`define WWT_ADDR_CTRL 32'h4000_4008
`define WWT_ADDR_KEY 32'h4000_400C
`define WWT_ADDR_FLAGS 32'h4000_4018
`define WWT_ADDR_FLOOR 32'h4000_401C

// Reset values
`define WWT_RST_LOAD 16'h1000
`define WWT_RST_CTRL 16'h00E9
`define WWT_RST_FLOOR 16'h0800
`define WWT_ZERO16 16'h0000

// Writable control bits; the others keep their reset value
`define WWT_CTRL_WMASK 16'h076F

// Refresh key and free running wrap value
`define WWT_KEY 16'hCCCC
`define WWT_FREE_WRAP 16'h1000

// Status flag positions
`define WWT_FLAG_IRQ 0
`define WWT_FLAG_REFRESH 1

// Prescaler masks for divide by 1, 16, 256, 4096
`define WWT_PRE_DIV1 12'h000
`define WWT_PRE_DIV16 12'h00F
`define WWT_PRE_DIV256 12'h0FF
`define WWT_PRE_DIV4096 12'hFFF
`define WWT_PRE_ZERO 12'h000
`define WWT_PRE_ONE 12'h001

// Low-frequency tick derived from the system clock
`define WWT_CLK_HZ 125000000
`define WWT_LF_HZ 32000
`define WWT_LF_CYCLES (`WWT_CLK_HZ / `WWT_LF_HZ)

`endif

/* core/wwt_pkg.sv */
// Types shared by the windowed watchdog design
package wwt_pkg;

  // Control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic [4:0] rsvdHi;
    logic irqEnable;
    logic windowCheckOn;
    logic clkDiv2;
    logic rsvd7;
    logic countStyle;
    logic runEnable;
    logic rsvd4;
    logic [1:0] prescale;
    logic irqMode;
    logic hibernateHalt;
  } wwt_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } wwt_req_t;

  // Prescaler codes
  typedef enum logic [1:0] {
    WWT_DIV1 = 2'h0,
    WWT_DIV16 = 2'h1,
    WWT_DIV256 = 2'h2,
    WWT_DIV4096 = 2'h3
  } wwt_pre_t;

  // Counter control states
  typedef enum logic [1:0] {
    WWT_IDLE,
    WWT_COUNT,
    WWT_TRIPPED
  } wwt_state_t;

endpackage

/* core/wwt_top.sv */
// Windowed 16-bit watchdog timer with register port
`timescale 1ns/1ps
`include "wwt_params.svh"
// Behaviour
// - Counter runs on 32 kHz low-frequency tick
// - 16-bit down-counter behind 1/16/256/4096 prescaler
// - Zero count causes reset, or interrupt
// - Key 0xCCCC reloads counter, restarts period
// - Any other key forces reset or interrupt
// - Control locked after a software write sets run switch
// - Early refresh in window mode faults
// - Counts in debug; stops in reset, hibernate-halt
// - Fault output logic lives in tick domain
// - Comes up enabled with long default timeout
// - Load value resets to 0x1000, starts count
// - Window floor resets to 0x0800
// - Count readback shows live count, read-only
// - Interrupt instead of reset is selectable
// - Interrupt mode ignores hibernate-halt bit
// - Prescale codes 00..11 select 1..4096
// - Control bit 1 picks interrupt over reset
// - Bit 0 suspends counting during hibernate
// - Bit 6 periodic, else free running wrap
module wwt_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic hibernate,
  output logic [15:0] regRdata,
  output logic chipReset,
  output logic wdIrq
);
  import wwt_pkg::*;

  // Request bundle
  wwt_req_t req;
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Registers
  logic [15:0] loadQ, loadD;
  logic [15:0] floorQ, floorD;
  wwt_ctrl_t ctrlQ, ctrlD;
  logic lockQ, lockD;
  logic [15:0] countQ, countD;
  logic [11:0] preQ, preD;
  logic [11:0] lfDivQ, lfDivD;
  logic refreshPendQ, refreshPendD;
  logic badKeyQ, badKeyD;
  logic irqPendQ, irqPendD;
  logic chipResetQ, chipResetD;
  logic wdIrqQ, wdIrqD;
  logic [15:0] rdataQ, rdataD;
  wwt_state_t stateQ, stateD;

  // Address decode
  wire selLoad = req.addr == `WWT_ADDR_LOAD;
  wire selCount = req.addr == `WWT_ADDR_COUNT;
  wire selCtrl = req.addr == `WWT_ADDR_CTRL;
  wire selKey = req.addr == `WWT_ADDR_KEY;
  wire selFlags = req.addr == `WWT_ADDR_FLAGS;
  wire selFloor = req.addr == `WWT_ADDR_FLOOR;

  // Write strobes per register
  wire wrLoad = req.wr && selLoad;
  wire wrFloor = req.wr && selFloor;
  wire wrCtrl = req.wr && selCtrl && !lockQ;
  wire wrKey = req.wr && selKey;
  wire keyGood = req.wdata == `WWT_KEY;
  wire wrKeyGood = wrKey && keyGood;
  wire wrKeyBad = wrKey && !keyGood;

  // Low-frequency tick, one system cycle wide
  wire lfTick = lfDivQ == 12'(`WWT_LF_CYCLES - 1);
  assign lfDivD = lfTick ? `WWT_PRE_ZERO : lfDivQ + `WWT_PRE_ONE;

  // Prescaler mask from the two-bit code
  logic [11:0] preMask;
  always_comb begin
    unique case (wwt_pre_t'(ctrlQ.prescale))
      WWT_DIV1: preMask = `WWT_PRE_DIV1;
      WWT_DIV16: preMask = `WWT_PRE_DIV16;
      WWT_DIV256: preMask = `WWT_PRE_DIV256;
      WWT_DIV4096: preMask = `WWT_PRE_DIV4096;
    endcase
  end

  // Hibernate halt only in reset mode; interrupt mode keeps counting
  wire halted = hibernate && ctrlQ.hibernateHalt
    && !ctrlQ.irqMode;
  // Debug has no effect on counting by design
  wire counting = ctrlQ.runEnable && !halted;
  wire preHit = (preQ & preMask) == preMask;
  wire decTick = lfTick && counting && preHit;

  // Reload source depends on count style
  wire [15:0] reloadVal = ctrlQ.countStyle ? loadQ
    : `WWT_FREE_WRAP;

  // Faults evaluated on the tick only, so the action path is tick-timed
  wire earlyRefresh = ctrlQ.windowCheckOn
    && countQ > floorQ;
  wire applyRefresh = lfTick && refreshPendQ;
  wire refreshFault = applyRefresh && ctrlQ.runEnable && earlyRefresh;
  wire keyFault = lfTick && badKeyQ && ctrlQ.runEnable;
  wire zeroFault = decTick && countQ == `WWT_ZERO16;
  wire anyFault = (refreshFault || keyFault || zeroFault)
    && stateQ == WWT_COUNT;

  // Counter state machine
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      WWT_IDLE: if (ctrlQ.runEnable) stateD = WWT_COUNT;
      WWT_COUNT: begin
        if (anyFault && !ctrlQ.irqMode) stateD = WWT_TRIPPED;
        else if (!ctrlQ.runEnable) stateD = WWT_IDLE;
      end
      WWT_TRIPPED: stateD = WWT_TRIPPED;
    endcase
  end

  // Counter next value
  always_comb begin
    countD = countQ;
    if (applyRefresh && !earlyRefresh) begin
      countD = reloadVal;
    end else if (zeroFault) begin
      countD = reloadVal;
    end else if (decTick) begin
      countD = countQ - 16'h0001;
    end
  end

  // Prescaler restarts with each accepted refresh
  assign preD = (applyRefresh && !earlyRefresh) ? `WWT_PRE_ZERO
    : (lfTick && counting) ? preQ + `WWT_PRE_ONE : preQ;

  // Refresh flag: new write wins over the tick that clears it
  assign refreshPendD = wrKeyGood ? 1'b1
    : applyRefresh ? 1'b0 : refreshPendQ;
  assign badKeyD = wrKeyBad ? 1'b1 : lfTick ? 1'b0 : badKeyQ;

  // Sticky interrupt: a fault in the same tick beats the clearing key
  assign irqPendD = (anyFault && ctrlQ.irqMode) ? 1'b1
    : (applyRefresh && !earlyRefresh) ? 1'b0
    : irqPendQ;
  assign wdIrqD = irqPendD && ctrlQ.irqEnable;

  // Chip reset holds until the system reset comes back
  assign chipResetD = chipResetQ
    || (anyFault && !ctrlQ.irqMode);

  // Register writes; reserved control bits keep their value
  assign loadD = wrLoad ? req.wdata : loadQ;
  assign floorD = wrFloor ? req.wdata : floorQ;
  assign ctrlD = wrCtrl ? wwt_ctrl_t'((req.wdata & `WWT_CTRL_WMASK)
    | (ctrlQ & ~`WWT_CTRL_WMASK)) : ctrlQ;
  // Lock arms only on a software write that sets the run switch
  assign lockD = lockQ || (wrCtrl && req.wdata[5]);

  // Status flags view
  logic [15:0] flags;
  always_comb begin
    flags = `WWT_ZERO16;
    flags[`WWT_FLAG_IRQ] = irqPendQ;
    flags[`WWT_FLAG_REFRESH] = refreshPendQ;
  end

  // Read mux; key register and unmapped addresses read zero
  always_comb begin
    rdataD = `WWT_ZERO16;
    if (req.rd) begin
      if (selLoad) rdataD = loadQ;
      else if (selCount) rdataD = countQ;
      else if (selCtrl) rdataD = ctrlQ;
      else if (selFlags) rdataD = flags;
      else if (selFloor) rdataD = floorQ;
    end
  end

  // Bus-facing registers
  always_ff @(posedge clock) begin
    if (rst) begin
      loadQ <= `WWT_RST_LOAD;
      floorQ <= `WWT_RST_FLOOR;
      ctrlQ <= wwt_ctrl_t'(`WWT_RST_CTRL);
      lockQ <= 1'b0;
      rdataQ <= `WWT_ZERO16;
    end else begin
      loadQ <= loadD;
      floorQ <= floorD;
      ctrlQ <= ctrlD;
      lockQ <= lockD;
      rdataQ <= rdataD;
    end
  end

  // Tick-domain counter and fault logic
  always_ff @(posedge clock) begin
    if (rst) begin
      countQ <= `WWT_RST_LOAD;
      preQ <= `WWT_PRE_ZERO;
      lfDivQ <= `WWT_PRE_ZERO;
      refreshPendQ <= 1'b0;
      badKeyQ <= 1'b0;
      irqPendQ <= 1'b0;
      wdIrqQ <= 1'b0;
      chipResetQ <= 1'b0;
      stateQ <= WWT_IDLE;
    end else begin
      countQ <= countD;
      preQ <= preD;
      lfDivQ <= lfDivD;
      refreshPendQ <= refreshPendD;
      badKeyQ <= badKeyD;
      irqPendQ <= irqPendD;
      wdIrqQ <= wdIrqD;
      chipResetQ <= chipResetD;
      stateQ <= stateD;
    end
  end

  // Outputs straight from flops
  assign regRdata = rdataQ;
  assign chipReset = chipResetQ;
  assign wdIrq = wdIrqQ;

endmodule // wwt_top

/* tb/wwt_checker.sv */
// Port assertions for the windowed watchdog
`timescale 1ns/1ps
`include "wwt_params.svh"
module wwt_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic chipReset,
  input wire logic wdIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Read data only in the slot after a read
  property p_rdIdle;
    regRdata != 16'h0000 |-> $past(regRd);
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray data");
  // Reset request holds until the next reset
  property p_rstHold;
    chipReset |=> chipReset;
  endproperty
  a_rstHold: assert property (p_rstHold) else $error("reset drop");
  property p_keyRd;
    regRd && regAddr == `WWT_ADDR_KEY |=> regRdata == 16'h0000;
  endproperty
  a_keyRd: assert property (p_keyRd) else $error("key read");
  property p_flagsRd;
    regRd && regAddr == `WWT_ADDR_FLAGS |=> regRdata[15:2] == 14'h0000;
  endproperty
  a_flagsRd: assert property (p_flagsRd) else $error("flags");
  // Write then read back, one cycle apart
  property p_loadRw;
    regWr && regAddr == `WWT_ADDR_LOAD ##1 regRd && regAddr == `WWT_ADDR_LOAD
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_loadRw: assert property (p_loadRw) else $error("load rw");
  property p_floorRw;
    regWr && regAddr == `WWT_ADDR_FLOOR ##1 regRd && regAddr == `WWT_ADDR_FLOOR
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_floorRw: assert property (p_floorRw) else $error("floor rw");
  // Reserved control bits keep their reset level
  property p_ctrlFix;
    regRd && regAddr == `WWT_ADDR_CTRL
      |=> regRdata[15:11] == 5'h00 && regRdata[7] && !regRdata[4];
  endproperty
  a_ctrlFix: assert property (p_ctrlFix) else $error("ctrl bits");
  property p_holeRd;
    regRd && regAddr == 32'h4000_4010 |=> regRdata == 16'h0000;
  endproperty
  a_holeRd: assert property (p_holeRd) else $error("hole read");
  c_irq: cover property ($rose(wdIrq));
  c_rst: cover property ($rose(chipReset));
  c_key: cover property (regWr && regAddr == `WWT_ADDR_KEY);
endmodule // wwt_checker

bind wwt_top wwt_checker u_wwt_checker (.clock(clock), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .chipReset(chipReset), .wdIrq(wdIrq));

/* tb/wwt_rst_ctl.sv */
// Reset controller model that latches watchdog requests
`timescale 1ns/1ps
module wwt_rst_ctl (
  input wire logic clock,
  input wire logic rst,
  input wire logic chipReset,
  output logic rstSeen
);
  // Sticky, so a short request is never missed
  always_ff @(posedge clock) begin
    if (rst) begin
      rstSeen <= 1'b0;
    end else if (chipReset) begin
      rstSeen <= 1'b1;
    end
  end
endmodule // wwt_rst_ctl

/* tb/wwt_top_test.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`include "wwt_params.svh"
module wwt_top_test;
  logic clock, rst, regWr, regRd, hibernate, chipReset, wdIrq, rstSeen;
  logic [31:0] regAddr;
  logic [15:0] regWdata, regRdata, v;
  int errors = 0;
  int n_compared = 0;
  wwt_top u_wwt_top (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .hibernate(hibernate), .regRdata(regRdata), .chipReset(chipReset),
    .wdIrq(wdIrq));
  wwt_rst_ctl u_wwt_rst_ctl (.clock(clock), .rst(rst),
    .chipReset(chipReset), .rstSeen(rstSeen));
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus cycle; every signal set once per edge
  task bus(input logic [31:0] a, input logic [15:0] d, input logic w,
    input logic r);
    regAddr <= a;
    regWdata <= d;
    regWr <= w;
    regRd <= r;
    @(posedge clock);
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    bus(a, d, 1'b1, 1'b0);
    bus(a, d, 1'b0, 1'b0);
  endtask
  // Data is only valid in the slot after the strobe
  task get(input logic [31:0] a);
    bus(a, 16'h0000, 1'b0, 1'b1);
    #1 v = regRdata;
    bus(a, 16'h0000, 1'b0, 1'b0);
  endtask
  task rd(input string n, input logic [31:0] a, input logic [15:0] e);
    get(a);
    check(n, v, e);
  endtask
  task doReset;
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
  endtask
  // Wait for a pending refresh to reach the tick domain
  task idleFlag;
    int k;
    k = 0;
    v = 16'h0002;
    while (v[1] !== 1'b0 && k < 3000) begin
      get(`WWT_ADDR_FLAGS);
      k++;
    end
  endtask
  task refresh(input logic [15:0] key);
    idleFlag;
    wr(`WWT_ADDR_KEY, key);
  endtask
  task waitOut(input logic irq, input logic lvl);
    int k;
    k = 0;
    while ((irq ? wdIrq : chipReset) !== lvl && k < 30000) begin
      @(posedge clock);
      k++;
    end
    #1 check("out", {15'h0000, irq ? wdIrq : chipReset}, {15'h0000, lvl});
  endtask
  task t_reset;
    rd("load", `WWT_ADDR_LOAD, 16'h1000);
    rd("ctrl", `WWT_ADDR_CTRL, 16'h00E9);
    rd("floor", `WWT_ADDR_FLOOR, 16'h0800);
    rd("flags", `WWT_ADDR_FLAGS, 16'h0000);
    rd("key", `WWT_ADDR_KEY, 16'h0000);
    rd("hole", 32'h4000_4010, 16'h0000);
    wr(`WWT_ADDR_COUNT, 16'h0055);
    rd("count", `WWT_ADDR_COUNT, 16'h1000);
    $display("reset test done");
  endtask
  task t_irq;
    bus(`WWT_ADDR_LOAD, 16'h0003, 1'b1, 1'b0);
    rd("load", `WWT_ADDR_LOAD, 16'h0003);
    bus(`WWT_ADDR_FLOOR, 16'h0001, 1'b1, 1'b0);
    rd("floor", `WWT_ADDR_FLOOR, 16'h0001);
    wr(`WWT_ADDR_CTRL, 16'h0462);
    wr(`WWT_ADDR_CTRL, 16'h0000);
    rd("ctrl", `WWT_ADDR_CTRL, 16'h04E2);
    refresh(16'hCCCC);
    rd("flags", `WWT_ADDR_FLAGS, 16'h0002);
    idleFlag;
    rd("count", `WWT_ADDR_COUNT, 16'h0003);
    refresh(16'h1234);
    waitOut(1'b1, 1'b1);
    check("chipReset", {15'h0000, chipReset}, 16'h0000);
    rd("flags", `WWT_ADDR_FLAGS, 16'h0001);
    refresh(16'hCCCC);
    waitOut(1'b1, 1'b0);
    waitOut(1'b1, 1'b1);
    $display("irq test done");
  endtask
  task t_window;
    doReset;
    wr(`WWT_ADDR_LOAD, 16'h0010);
    wr(`WWT_ADDR_FLOOR, 16'h0008);
    wr(`WWT_ADDR_CTRL, 16'h0260);
    refresh(16'hCCCC);
    waitOut(1'b0, 1'b1);
    check("seen", {15'h0000, rstSeen}, 16'h0001);
    $display("window test done");
  endtask
  // Disabled timer in free running style: reload is the wrap value
  task t_free;
    doReset;
    wr(`WWT_ADDR_LOAD, 16'h0005);
    wr(`WWT_ADDR_CTRL, 16'h0000);
    refresh(16'hCCCC);
    idleFlag;
    rd("wrap", `WWT_ADDR_COUNT, 16'h1000);
    repeat (3906) @(posedge clock);
    rd("still", `WWT_ADDR_COUNT, 16'h1000);
    check("quiet", {15'h0000, chipReset}, 16'h0000);
    $display("free test done");
  endtask
  task t_timeout;
    doReset;
    wr(`WWT_ADDR_LOAD, 16'h0002);
    wr(`WWT_ADDR_CTRL, 16'h0061);
    refresh(16'hCCCC);
    idleFlag;
    rd("count", `WWT_ADDR_COUNT, 16'h0002);
    hibernate <= 1'b1;
    repeat (7812) @(posedge clock);
    rd("hold", `WWT_ADDR_COUNT, 16'h0002);
    hibernate <= 1'b0;
    waitOut(1'b0, 1'b1);
    $display("timeout test done");
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    regAddr = 32'h0000_0000;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    hibernate = 1'b0;
    doReset;
    t_reset;
    t_irq;
    t_window;
    t_free;
    t_timeout;
    print_verdict;
  end
  // Cut a hang short well past the expected run
  initial begin
    repeat (95000) @(posedge clock);
    errors++;
    print_verdict;
  end
endmodule // wwt_top_test
